// ==== rtl/lsec_pkg.sv ====
// constants, codes and shared helpers for the load switch enable control
package lsec_pkg;

	// --------------------------------------------------------------
	// register offsets
	// --------------------------------------------------------------
	localparam logic [7:0] SW1_PIN_SELECT_OFS = 8'h5b;
	localparam logic [7:0] SW2_ENABLE_OFS     = 8'h5c;
	localparam logic [7:0] SW2_CONFIG_OFS     = 8'h5d;
	localparam logic [7:0] SW2_PIN_SELECT_OFS = 8'h5e;

	// --------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------
	localparam int SEQ_LSB  = 5;
	localparam int EN_LSB   = 0;
	localparam int ACT_BIT  = 2;
	localparam int LOWQ_BIT = 1;
	localparam int PSV_BIT  = 0;

	// --------------------------------------------------------------
	// reset values
	// --------------------------------------------------------------
	localparam logic [1:0] SOFT_ENABLE_RST = 2'h0;
	localparam logic [2:0] CONFIG_RST      = 3'h0;
	localparam logic [7:0] PIN_SELECT_RST  = 8'h00;
	localparam logic [7:0] READ_ZERO       = 8'h00;

	// --------------------------------------------------------------
	// field codes
	// --------------------------------------------------------------
	typedef enum logic [2:0] {
		SEQ_OFF  = 3'b000,
		SEQ_AT0  = 3'b010,
		SEQ_AT25 = 3'b011,
		SEQ_AT50 = 3'b100,
		SEQ_SOFT = 3'b111
	} lsec_seq_e;

	typedef enum logic [1:0] {
		EN_OFF = 2'b00,
		EN_ON  = 2'b01,
		EN_PIN = 2'b10
	} lsec_en_e;

	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int CLK_MHZ           = 250;
	localparam int BOOT_DELAY_US     = 100;
	localparam int BOOT_DELAY_CYCLES = BOOT_DELAY_US * CLK_MHZ;

	// OR of the selected multipurpose inputs
	function automatic logic lsec_pin_or(input logic [7:0] pins, input logic [7:0] sel);
		return |(pins & sel);
	endfunction

endpackage

// ==== rtl/lsec_boot_if.sv ====
// boot progress milestones passed from the boot timer to the control
`timescale 1ns/100ps
`default_nettype none
interface lsec_boot_if;
	logic at25;
	logic at50;
	logic done;
	modport timer (output at25, output at50, output done);
	modport ctrl  (input at25, input at50, input done);
endinterface
`default_nettype wire

// ==== rtl/lsec_boot_timer.sv ====
// boot delay counter raising 25, 50 and 100 percent milestones
`timescale 1ns/100ps
`default_nettype none
module lsec_boot_timer #(
	parameter int BOOT_CYCLES = lsec_pkg::BOOT_DELAY_CYCLES
) (
	// clock and reset
	input  wire logic  core_clk_in,
	input  wire logic  rstn_in,
	// milestones
	lsec_boot_if.timer boot
);
	localparam int CW = $clog2(BOOT_CYCLES + 1);

	// the quarter milestone needs at least one count of its own
	if (BOOT_CYCLES < 4)
	begin : g_boot_check
		$error("boot delay must be at least four cycles");
	end

	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic [2:0]    mile_reg;
	logic [2:0]    mile_next;

	always_comb
	begin
		cnt_next  = cnt_reg;
		if (cnt_reg != CW'(BOOT_CYCLES))
			cnt_next = cnt_reg + CW'(1);
		mile_next = {cnt_next >= CW'(BOOT_CYCLES),
		             cnt_next >= CW'(BOOT_CYCLES / 2),
		             cnt_next >= CW'(BOOT_CYCLES / 4)};
	end

	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			cnt_reg  <= '0;
			mile_reg <= 3'h0;
		end
		else
		begin
			cnt_reg  <= cnt_next;
			mile_reg <= mile_next;
		end
	end

	assign boot.at25 = mile_reg[0];
	assign boot.at50 = mile_reg[1];
	assign boot.done = mile_reg[2];
endmodule
`default_nettype wire

// ==== rtl/lsec_ctrl.sv ====
// enable control and configuration registers of the second load switch
//
// Contract
// - sequence strap 000 off; 010/011/100 turn on at 0/25/50% boot delay.
// - sequence 111 hands the switch to the soft enable after full boot delay.
// - soft enable obeyed only under 111: 00 off, 01 on, 10 pins.
// - pin mode takes the switch state from inputs selected at 0x5e.
// - first switch pin bits select inputs, valid under 111 and 10, ORed.
// - config bit 2 set: active discharge also while enable is low.
// - config bit 1 clear keeps drop protection on; set turns it off.
// - config bit 0 set: passive discharge also while enable is low.
// - second switch pin bits valid only under 111 and 10, ORed.
`timescale 1ns/100ps
`default_nettype none
module lsec_ctrl #(
	parameter int BOOT_CYCLES = lsec_pkg::BOOT_DELAY_CYCLES
) (
	// clock and reset
	input  wire logic       core_clk_in,
	input  wire logic       rstn_in,
	// register port
	input  wire logic [7:0] reg_addr_in,
	input  wire logic       reg_wr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_rd_in,
	output logic      [7:0] reg_rdata_out,
	// straps and first switch state
	input  wire logic [2:0] sw2_boot_sequence_in,
	input  wire logic [2:0] sw1_boot_sequence_in,
	input  wire logic [1:0] sw1_soft_enable_in,
	// power mode events
	input  wire logic       hard_reset_mode_in,
	input  wire logic       off_entry_in,
	// multipurpose inputs
	input  wire logic [7:0] multipurpose_input_in,
	// switch controls
	output logic            sw2_enable_out,
	output logic            sw2_active_discharge_out,
	output logic            sw2_passive_discharge_out,
	output logic            sw2_protect_enable_out,
	output logic            sw1_pin_enable_out
);
	lsec_boot_if boot_if ();

	lsec_boot_timer #(.BOOT_CYCLES(BOOT_CYCLES)) u_timer (
		.core_clk_in (core_clk_in),
		.rstn_in     (rstn_in),
		.boot        (boot_if.timer)
	);

	// --------------------------------------------------------------
	// register state
	// --------------------------------------------------------------
	logic [2:0] seq_reg;
	logic [2:0] seq_next;
	logic       strap_reg;
	logic [1:0] en_reg;
	logic [1:0] en_next;
	logic [2:0] cfg_reg;
	logic [2:0] cfg_next;
	logic [7:0] sel2_reg;
	logic [7:0] sel2_next;
	logic [7:0] sel1_reg;
	logic [7:0] sel1_next;
	logic [7:0] rdata_next;

	always_comb
	begin
		seq_next   = strap_reg ? seq_reg : sw2_boot_sequence_in;
		en_next    = en_reg;
		cfg_next   = cfg_reg;
		sel2_next  = sel2_reg;
		sel1_next  = sel1_reg;
		rdata_next = reg_rdata_out;
		if (reg_wr_in)
		begin
			case (reg_addr_in)
				lsec_pkg::SW2_ENABLE_OFS:     en_next   = reg_wdata_in[lsec_pkg::EN_LSB +: 2];
				lsec_pkg::SW2_CONFIG_OFS:     cfg_next  = reg_wdata_in[2:0];
				lsec_pkg::SW2_PIN_SELECT_OFS: sel2_next = reg_wdata_in;
				lsec_pkg::SW1_PIN_SELECT_OFS: sel1_next = reg_wdata_in;
				default:                      en_next   = en_reg;
			endcase
		end
		if (reg_rd_in)
		begin
			case (reg_addr_in)
				lsec_pkg::SW2_ENABLE_OFS:     rdata_next = {seq_reg, 3'h0, en_reg};
				lsec_pkg::SW2_CONFIG_OFS:     rdata_next = {5'h00, cfg_reg};
				lsec_pkg::SW2_PIN_SELECT_OFS: rdata_next = sel2_reg;
				lsec_pkg::SW1_PIN_SELECT_OFS: rdata_next = sel1_reg;
				default:                      rdata_next = lsec_pkg::READ_ZERO;
			endcase
		end
	end

	// the strap is caught on the first edge after reset release
	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			seq_reg       <= 3'h0;
			strap_reg     <= 1'b0;
			en_reg        <= lsec_pkg::SOFT_ENABLE_RST;
			cfg_reg       <= lsec_pkg::CONFIG_RST;
			sel2_reg      <= lsec_pkg::PIN_SELECT_RST;
			sel1_reg      <= lsec_pkg::PIN_SELECT_RST;
			reg_rdata_out <= lsec_pkg::READ_ZERO;
		end
		else
		begin
			seq_reg       <= seq_next;
			strap_reg     <= 1'b1;
			en_reg        <= en_next;
			cfg_reg       <= cfg_next;
			sel2_reg      <= sel2_next;
			sel1_reg      <= sel1_next;
			reg_rdata_out <= rdata_next;
		end
	end

	// --------------------------------------------------------------
	// switch decisions
	// --------------------------------------------------------------
	logic ena_next;
	logic act_next;
	logic psv_next;
	logic sw1_next;

	always_comb
	begin
		ena_next = 1'b0;
		if (strap_reg)
		begin
			case (seq_reg)
				lsec_pkg::SEQ_OFF:  ena_next = 1'b0;
				lsec_pkg::SEQ_AT0:  ena_next = 1'b1;
				lsec_pkg::SEQ_AT25: ena_next = boot_if.at25;
				lsec_pkg::SEQ_AT50: ena_next = boot_if.at50;
				lsec_pkg::SEQ_SOFT:
				begin
					case (en_reg)
						lsec_pkg::EN_ON:  ena_next = boot_if.done;
						lsec_pkg::EN_PIN: ena_next = boot_if.done
						                  & lsec_pkg::lsec_pin_or(multipurpose_input_in, sel2_reg);
						default:          ena_next = 1'b0;
					endcase
				end
				default:            ena_next = 1'b0;
			endcase
		end
		act_next = hard_reset_mode_in | (cfg_reg[lsec_pkg::ACT_BIT] & ~ena_next);
		psv_next = off_entry_in | hard_reset_mode_in
		         | (cfg_reg[lsec_pkg::PSV_BIT] & ~ena_next);
		sw1_next = boot_if.done & (sw1_boot_sequence_in == lsec_pkg::SEQ_SOFT)
		         & (sw1_soft_enable_in == lsec_pkg::EN_PIN)
		         & lsec_pkg::lsec_pin_or(multipurpose_input_in, sel1_reg);
	end

	always_ff @(posedge core_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			sw2_enable_out            <= 1'b0;
			sw2_active_discharge_out  <= 1'b0;
			sw2_passive_discharge_out <= 1'b0;
			sw2_protect_enable_out    <= 1'b1;
			sw1_pin_enable_out        <= 1'b0;
		end
		else
		begin
			sw2_enable_out            <= ena_next;
			sw2_active_discharge_out  <= act_next;
			sw2_passive_discharge_out <= psv_next;
			sw2_protect_enable_out    <= ~cfg_reg[lsec_pkg::LOWQ_BIT];
			sw1_pin_enable_out        <= sw1_next;
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	sequence soft_on_s;
		seq_reg == lsec_pkg::SEQ_SOFT && en_reg == lsec_pkg::EN_ON && boot_if.done;
	endsequence
	sequence pin_on_s;
		seq_reg == lsec_pkg::SEQ_SOFT && en_reg == lsec_pkg::EN_PIN && boot_if.done
		&& (multipurpose_input_in & sel2_reg) != 8'h00;
	endsequence

	seq_off_a: assert property (strap_reg && seq_reg == lsec_pkg::SEQ_OFF |=> !sw2_enable_out)
		else $error("switch on with sequence off");
	seq_at0_a: assert property (strap_reg && seq_reg == lsec_pkg::SEQ_AT0 |=> sw2_enable_out)
		else $error("switch off with sequence at zero");
	seq_at25_a: assert property (strap_reg && seq_reg == lsec_pkg::SEQ_AT25
		|=> sw2_enable_out == $past(boot_if.at25))
		else $error("quarter delay enable wrong");
	seq_at50_a: assert property (strap_reg && seq_reg == lsec_pkg::SEQ_AT50
		|=> sw2_enable_out == $past(boot_if.at50))
		else $error("half delay enable wrong");
	soft_wait_a: assert property (seq_reg == lsec_pkg::SEQ_SOFT && !boot_if.done |=> !sw2_enable_out)
		else $error("soft control before boot done");
	soft_on_a: assert property (strap_reg ##0 soft_on_s |=> sw2_enable_out)
		else $error("soft enable ignored");
	pin_or_a: assert property (strap_reg ##0 pin_on_s |=> sw2_enable_out)
		else $error("pin control ignored");
	reserved_off_a: assert property ((seq_reg == lsec_pkg::SEQ_SOFT && en_reg == 2'b11)
		|| seq_reg inside {3'b001, 3'b101, 3'b110}
		|=> !sw2_enable_out)
		else $error("reserved code turned switch on");
	act_dis_a: assert property (cfg_reg[lsec_pkg::ACT_BIT] && !ena_next |=> sw2_active_discharge_out)
		else $error("active discharge missing");
	psv_dis_a: assert property (!cfg_reg[lsec_pkg::PSV_BIT] && !off_entry_in && !hard_reset_mode_in
		|=> !sw2_passive_discharge_out)
		else $error("passive discharge without cause");
	protect_a: assert property (##1 sw2_protect_enable_out == !$past(cfg_reg[lsec_pkg::LOWQ_BIT]))
		else $error("protection does not follow config");
	sw1_pin_a: assert property (sw1_soft_enable_in != lsec_pkg::EN_PIN |=> !sw1_pin_enable_out)
		else $error("first switch pin enable outside pin mode");
endmodule
`default_nettype wire

// ==== tb/lsec_ctrl_tb_top.sv ====
// self-checking testbench for the load switch enable control
`timescale 1ns/100ps
`default_nettype none
module lsec_ctrl_tb_top;
	localparam int BOOT = 16;
	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] multipurpose_input = 8'h00;
	logic [7:0] rdata;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       hr = 1'b0;
	logic       off = 1'b0;
	logic [2:0] seq2 = 3'h0;
	logic [2:0] seq1 = 3'h0;
	logic [1:0] en1 = 2'h0;
	logic       en2, act, psv, prot, pin1;
	int         fail_count = 0;
	int         num_checks = 0;

	always #2 clk = ~clk;

	lsec_ctrl #(.BOOT_CYCLES(BOOT)) i_lsec_ctrl (
		.core_clk_in(clk), .rstn_in(rstn), .reg_addr_in(addr), .reg_wr_in(wr),
		.reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.sw2_boot_sequence_in(seq2), .sw1_boot_sequence_in(seq1), .sw1_soft_enable_in(en1),
		.hard_reset_mode_in(hr), .off_entry_in(off), .multipurpose_input_in(multipurpose_input),
		.sw2_enable_out(en2), .sw2_active_discharge_out(act), .sw2_passive_discharge_out(psv),
		.sw2_protect_enable_out(prot), .sw1_pin_enable_out(pin1)
	);

	// --------------------------------------------------------------
	// access and compare tasks
	// --------------------------------------------------------------
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// outputs packed as enable, active, passive, protect, first switch pin
	task automatic chk_out(input logic [4:0] exp);
		chk("outputs", {3'h0, en2, act, psv, prot, pin1}, {3'h0, exp});
	endtask

	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		settle();
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("rdata", rdata, exp);
	endtask

	task automatic do_reset(input logic [2:0] s);
		@(posedge clk);
		rstn <= 1'b0;
		seq2 <= s;
		repeat (3) @(posedge clk);
		#1;
		chk_out(5'h02);
		@(posedge clk);
		rstn <= 1'b1;
	endtask

	task automatic drive(input logic [7:0] m, input logic h, input logic o);
		@(posedge clk);
		multipurpose_input <= m;
		hr <= h;
		off <= o;
		settle();
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	logic [7:0] pins [4] = '{8'h02, 8'h04, 8'h01, 8'h80};
	logic       pexp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

	initial
	begin
		do_reset(3'h7);
		wr_reg(8'h5c, 8'h01);
		chk_out(5'h02);
		repeat (BOOT + 4) @(posedge clk);
		#1;
		chk_out(5'h12);
		rd_reg(8'h5c, 8'he1);
		wr_reg(8'h5d, 8'h05);
		chk_out(5'h12);
		rd_reg(8'h5d, 8'h05);
		wr_reg(8'h5c, 8'h00);
		chk_out(5'h0e);
		wr_reg(8'h5d, 8'h02);
		chk_out(5'h00);
		drive(8'h00, 1'b1, 1'b0);
		chk_out(5'h0c);
		drive(8'h00, 1'b0, 1'b1);
		chk_out(5'h04);
		drive(8'h00, 1'b0, 1'b0);
		$display("test config done");
		wr_reg(8'h5e, 8'h05);
		wr_reg(8'h5c, 8'h02);
		for (int i = 0; i < 4; i++)
		begin
			drive(pins[i], 1'b0, 1'b0);
			chk_out({pexp[i], 4'h0});
		end
		wr_reg(8'h5c, 8'h03);
		drive(8'h05, 1'b0, 1'b0);
		chk_out(5'h00);
		rd_reg(8'h5c, 8'he3);
		rd_reg(8'h5e, 8'h05);
		wr_reg(8'h5f, 8'hff);
		rd_reg(8'h5f, 8'h00);
		$display("test pin control done");
		@(posedge clk);
		seq1 <= 3'h7;
		en1 <= 2'h2;
		wr_reg(8'h5b, 8'h40);
		rd_reg(8'h5b, 8'h40);
		drive(8'h40, 1'b0, 1'b0);
		chk_out(5'h01);
		drive(8'hbf, 1'b0, 1'b0);
		chk_out(5'h00);
		@(posedge clk);
		en1 <= 2'h1;
		drive(8'h40, 1'b0, 1'b0);
		chk_out(5'h00);
		@(posedge clk);
		seq1 <= 3'h4;
		en1 <= 2'h2;
		drive(8'h40, 1'b0, 1'b0);
		chk_out(5'h00);
		$display("test first switch done");
		for (int i = 0; i < 7; i++)
		begin
			do_reset(3'(i));
			repeat (3) @(posedge clk);
			#1;
			chk("boot early", {7'h00, en2}, {7'h00, i == 2});
			repeat (4) @(posedge clk);
			#1;
			chk("boot mid", {7'h00, en2}, {7'h00, i == 2 || i == 3});
			repeat (BOOT + 4) @(posedge clk);
			#1;
			chk("boot late", {7'h00, en2}, {7'h00, i >= 2 && i <= 4});
			rd_reg(8'h5c, {3'(i), 5'h00});
		end
		$display("test boot sequence done");
		finish_test();
	end
endmodule
`default_nettype wire
